// ---- inc/gpio_pkg.sv ----
// Constants, register map and field layout of the eight-pin I/O port.
// Assumes a 32-bit Wishbone slave with byte addresses; data sits in bits 7:0.
package gpio_pkg;
	localparam int          GPIO_PINS    = 8;
	localparam int          GPIO_DW      = 8;
	localparam logic [7:0]  GPIO_RST     = 8'h00;
	// Register byte offsets
	localparam logic [7:0]  OFS_DIR      = 8'h00;
	localparam logic [7:0]  OFS_DIRSET   = 8'h04;
	localparam logic [7:0]  OFS_DIRCLR   = 8'h08;
	localparam logic [7:0]  OFS_DIRTGL   = 8'h0c;
	localparam logic [7:0]  OFS_OUT      = 8'h10;
	localparam logic [7:0]  OFS_OUTSET   = 8'h14;
	localparam logic [7:0]  OFS_OUTCLR   = 8'h18;
	localparam logic [7:0]  OFS_OUTTGL   = 8'h1c;
	localparam logic [7:0]  OFS_IN       = 8'h20;
	localparam logic [7:0]  OFS_MASK0    = 8'h24;
	localparam logic [7:0]  OFS_MASK1    = 8'h28;
	localparam logic [7:0]  OFS_FLAGS    = 8'h2c;
	localparam logic [7:0]  OFS_MULTI    = 8'h30;
	localparam logic [7:0]  OFS_PCTRL    = 8'h34;
	localparam logic [7:0]  OFS_INTCTRL  = 8'h38;
	localparam logic [7:0]  OFS_VPCTRL   = 8'h3c;
	localparam logic [7:0]  OFS_PINCFG0  = 8'h40;
	localparam logic [7:0]  OFS_VP_DIR   = 8'h60;
	localparam logic [7:0]  OFS_VP_OUT   = 8'h64;
	localparam logic [7:0]  OFS_VP_IN    = 8'h68;
	localparam logic [7:0]  OFS_VP_FLAGS = 8'h6c;
	// Pin configuration fields
	localparam int          ISC_LSB      = 0;
	localparam int          ISC_MSB      = 1;
	localparam int          OPC_LSB      = 2;
	localparam int          OPC_MSB      = 4;
	localparam int          INV_BIT      = 6;
	// Port, virtual port and interrupt control bits; event and clock output pins
	localparam int          PC_CLKEN     = 0;
	localparam int          PC_EVOUT     = 1;
	localparam int          PC_CLKOUT    = 2;
	localparam int          VP_EN        = 0;
	localparam int          IL0_LSB      = 0;
	localparam int          IL1_LSB      = 2;
	localparam int          EVOUT_PIN    = 6;
	localparam int          CLKOUT_PIN   = 7;

	typedef enum logic [1:0] {ISC_BOTH, ISC_RISE, ISC_FALL, ISC_LEVEL} gpio_isc_e;
	typedef enum logic [2:0] {OPC_TOTEM, OPC_KEEP, OPC_PULLDN, OPC_PULLUP,
		OPC_WOR, OPC_WAND, OPC_WOR_PD, OPC_WAND_PU} gpio_opc_e;
endpackage

// ---- hdl/gpio_sync.sv ----
// Two-flop synchroniser for the pad inputs.
// Assumes the pads are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module gpio_sync (
	input  wire logic                         ref_clk_i, // Clock
	input  wire logic                         rst_n_i,   // Sync reset
	input  wire logic [gpio_pkg::GPIO_PINS-1:0] async_i, // Raw pads
	output logic      [gpio_pkg::GPIO_PINS-1:0] sync_o   // Synchronised
);
	import gpio_pkg::*;
	logic [GPIO_PINS-1:0] meta_q;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			meta_q <= GPIO_RST;
			sync_o <= GPIO_RST;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule

// ---- hdl/gpio_sense.sv ----
// Per-pin edge and level sensing on the already inverted input values.
// Assumes sig_i is synchronous to ref_clk_i.
`timescale 1ns/1ps
module gpio_sense (
	input  wire logic                              ref_clk_i, // Clock
	input  wire logic                              rst_n_i,   // Sync reset
	input  wire logic [gpio_pkg::GPIO_PINS-1:0]      sig_i,   // Pin values
	input  wire logic [gpio_pkg::GPIO_PINS-1:0][1:0] isc_i,   // Sense modes
	output logic      [gpio_pkg::GPIO_PINS-1:0]      hit_a_o, // Direct hit
	output logic      [gpio_pkg::GPIO_PINS-1:0]      hit_s_o  // Clocked hit
);
	import gpio_pkg::*;
	logic [GPIO_PINS-1:0] prev_q;

	for (genvar i = 0; i < GPIO_PINS; i++) begin : g_pin
		wire logic rise = sig_i[i] & ~prev_q[i];
		wire logic fall = ~sig_i[i] & prev_q[i];
		always_comb begin
			unique case (gpio_isc_e'(isc_i[i]))
				ISC_BOTH:  hit_a_o[i] = rise | fall;
				ISC_RISE:  hit_a_o[i] = rise;
				ISC_FALL:  hit_a_o[i] = fall;
				ISC_LEVEL: hit_a_o[i] = ~sig_i[i];
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			prev_q  <= GPIO_RST;
			hit_s_o <= GPIO_RST;
		end else begin
			prev_q  <= sig_i;
			hit_s_o <= hit_a_o;
		end
	end
endmodule

// ---- hdl/gpio_port.sv ----
// Eight-pin general purpose I/O port with Wishbone register access.
// Assumes pads resolve pad_out_o/pad_oe_n_o and weak pulls outside;
// alternate function and event inputs are on ref_clk_i.
`timescale 1ns/1ps
module gpio_port (
	input  wire logic        ref_clk_i,   // 100 MHz clock
	input  wire logic        rst_n_i,     // Sync reset, active low
	input  wire logic        wb_cyc_i,    // Bus cycle
	input  wire logic        wb_stb_i,    // Strobe
	input  wire logic        wb_we_i,     // Write enable
	input  wire logic [7:0]  wb_adr_i,    // Byte address
	input  wire logic [3:0]  wb_sel_i,    // Byte lanes
	input  wire logic [31:0] wb_dat_i,    // Write data
	output logic      [31:0] wb_dat_o,    // Read data
	output logic             wb_ack_o,    // Acknowledge
	input  wire logic [gpio_pkg::GPIO_PINS-1:0] pad_in_i,   // Pad level
	output logic      [gpio_pkg::GPIO_PINS-1:0] pad_out_o,  // Pad drive value
	output logic      [gpio_pkg::GPIO_PINS-1:0] pad_oe_n_o, // Drive, low active
	output logic      [gpio_pkg::GPIO_PINS-1:0] pad_pu_o,   // Weak pull-up
	output logic      [gpio_pkg::GPIO_PINS-1:0] pad_pd_o,   // Weak pull-down
	input  wire logic [gpio_pkg::GPIO_PINS-1:0] alt_en_i,   // Peripheral owns pin
	input  wire logic [gpio_pkg::GPIO_PINS-1:0] alt_out_i,  // Peripheral value
	input  wire logic [gpio_pkg::GPIO_PINS-1:0] alt_dir_i,  // Peripheral drives
	output logic      [gpio_pkg::GPIO_PINS-1:0] alt_in_o,   // Input to peripheral
	input  wire logic        ev7_i,       // Event channel 7
	output logic      [gpio_pkg::GPIO_PINS-1:0] sense_o,    // Sense events
	output logic      [1:0]  irq_o,       // Port interrupts
	output logic      [1:0]  irq_lvl0_o,  // Priority of interrupt 0
	output logic      [1:0]  irq_lvl1_o,  // Priority of interrupt 1
	output logic             wake_o       // Wake-up request
);
	import gpio_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// State
	logic [GPIO_DW-1:0]   dir_q, dir_d, out_q, out_d;
	logic [GPIO_DW-1:0]   mask0_q, mask1_q, multi_q, pctrl_q, ictrl_q, vp_q;
	logic [GPIO_DW-1:0]   cfg_q [GPIO_PINS];
	logic [1:0]           flag_q, flag_d;
	logic [GPIO_PINS-1:0] keep_q, in_q, pin_s;
	logic                 clkdiv_q, ack_q;
	logic [GPIO_DW-1:0]   dat_q, rd_data;
	logic [GPIO_PINS-1:0] hit_a, hit_s, hit;
	logic [GPIO_PINS-1:0][1:0] isc;
	logic [GPIO_PINS-1:0] inv, drv_v, drv_en, oe, pu, pd;

	////////////////////////////////////////////////////////////////////////////////
	// Bus decode
	wire logic             req     = wb_cyc_i & wb_stb_i & ~ack_q;
	wire logic             wr      = req & wb_we_i & wb_sel_i[0];
	wire logic [7:0]       wd      = wb_dat_i[GPIO_DW-1:0];
	wire logic             vp_en   = vp_q[VP_EN];
	wire logic             a_dir   = (wb_adr_i == OFS_DIR) | (vp_en & (wb_adr_i == OFS_VP_DIR));
	wire logic             a_out   = (wb_adr_i == OFS_OUT) | (vp_en & (wb_adr_i == OFS_VP_OUT));
	wire logic             a_in    = (wb_adr_i == OFS_IN) | (vp_en & (wb_adr_i == OFS_VP_IN));
	wire logic             a_flg   = (wb_adr_i == OFS_FLAGS) | (vp_en & (wb_adr_i == OFS_VP_FLAGS));
	wire logic             a_cfg   = wb_adr_i[7:5] == OFS_PINCFG0[7:5];
	wire logic [2:0]       cfg_idx = wb_adr_i[4:2];
	wire logic             w_dir   = wr & a_dir;
	wire logic             w_dset  = wr & (wb_adr_i == OFS_DIRSET);
	wire logic             w_dclr  = wr & (wb_adr_i == OFS_DIRCLR);
	wire logic             w_dtgl  = wr & (wb_adr_i == OFS_DIRTGL);
	wire logic             w_out   = wr & a_out;
	wire logic             w_oset  = wr & (wb_adr_i == OFS_OUTSET);
	wire logic             w_oclr  = wr & (wb_adr_i == OFS_OUTCLR);
	wire logic             w_otgl  = wr & (wb_adr_i == OFS_OUTTGL);
	wire logic             w_flg   = wr & a_flg;
	wire logic             w_cfg   = wr & a_cfg;
	wire logic [GPIO_PINS-1:0] cfg_sel = (multi_q != GPIO_RST) ? multi_q
		: GPIO_PINS'(1) << cfg_idx;

	////////////////////////////////////////////////////////////////////////////////
	// Direction and output with set/clear/toggle
	always_comb begin
		dir_d = dir_q;
		if (w_dir)
			dir_d = wd;
		else if (w_dset)
			dir_d = dir_q | wd;
		else if (w_dclr)
			dir_d = dir_q & ~wd;
		else if (w_dtgl)
			dir_d = dir_q ^ wd;
		out_d = out_q;
		if (w_out)
			out_d = wd;
		else if (w_oset)
			out_d = out_q | wd;
		else if (w_oclr)
			out_d = out_q & ~wd;
		else if (w_otgl)
			out_d = out_q ^ wd;
	end

	// Flags: a new hit wins over a write-one clear in the same cycle
	for (genvar k = 0; k < 2; k++) begin : g_flag
		wire logic [GPIO_PINS-1:0] msk = (k == 0) ? mask0_q : mask1_q;
		assign flag_d[k] = (|(msk & hit)) | (flag_q[k] & ~(w_flg & wd[k]));
	end

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			dir_q   <= GPIO_RST;
			out_q   <= GPIO_RST;
			mask0_q <= GPIO_RST;
			mask1_q <= GPIO_RST;
			multi_q <= GPIO_RST;
			pctrl_q <= GPIO_RST;
			ictrl_q <= GPIO_RST;
			vp_q    <= GPIO_RST;
			flag_q  <= 2'h0;
		end else begin
			dir_q  <= dir_d;
			out_q  <= out_d;
			flag_q <= flag_d;
			if (wr && wb_adr_i == OFS_MASK0)
				mask0_q <= wd;
			if (wr && wb_adr_i == OFS_MASK1)
				mask1_q <= wd;
			if (wr && wb_adr_i == OFS_PCTRL)
				pctrl_q <= wd;
			if (wr && wb_adr_i == OFS_INTCTRL)
				ictrl_q <= wd;
			if (wr && wb_adr_i == OFS_VPCTRL)
				vp_q <= wd;
			// Selection is used once, then falls back to single-pin writes
			if (wr && wb_adr_i == OFS_MULTI)
				multi_q <= wd;
			else if (w_cfg)
				multi_q <= GPIO_RST;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Pin configuration, one register per pin
	for (genvar i = 0; i < GPIO_PINS; i++) begin : g_cfg
		always_ff @(posedge ref_clk_i) begin
			if (!rst_n_i)
				cfg_q[i] <= GPIO_RST;
			else if (w_cfg && cfg_sel[i])
				cfg_q[i] <= wd;
		end
		assign inv[i] = cfg_q[i][INV_BIT];
		assign isc[i] = cfg_q[i][ISC_MSB:ISC_LSB];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Read mux and acknowledge
	always_comb begin
		rd_data = GPIO_RST;
		if (a_dir)
			rd_data = dir_q;
		else if (a_out)
			rd_data = out_q;
		else if (a_in)
			rd_data = in_q;
		else if (a_flg)
			rd_data = {6'h00, flag_q};
		else if (a_cfg)
			rd_data = cfg_q[cfg_idx];
		else if (wb_adr_i == OFS_MASK0)
			rd_data = mask0_q;
		else if (wb_adr_i == OFS_MASK1)
			rd_data = mask1_q;
		else if (wb_adr_i == OFS_MULTI)
			rd_data = multi_q;
		else if (wb_adr_i == OFS_PCTRL)
			rd_data = pctrl_q;
		else if (wb_adr_i == OFS_INTCTRL)
			rd_data = ictrl_q;
		else if (wb_adr_i == OFS_VPCTRL)
			rd_data = vp_q;
	end

	// Every address is acknowledged; unmapped ones read zero
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			ack_q <= 1'b0;
			dat_q <= GPIO_RST;
		end else begin
			ack_q <= req;
			if (req)
				dat_q <= rd_data;
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = {24'h000000, dat_q};

	////////////////////////////////////////////////////////////////////////////////
	// Input path and sensing
	gpio_sync u_sync (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.async_i   (pad_in_i),
		.sync_o    (pin_s)
	);

	wire logic [GPIO_PINS-1:0] in_v = pin_s ^ inv;

	gpio_sense u_sense (
		.ref_clk_i (ref_clk_i),
		.rst_n_i   (rst_n_i),
		.sig_i     (in_v),
		.isc_i     (isc),
		.hit_a_o   (hit_a),
		.hit_s_o   (hit_s)
	);

	// Clocked path adds a cycle; direct path stays live for wake-up
	assign hit = pctrl_q[PC_CLKEN] ? hit_s : hit_a;

	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			in_q     <= GPIO_RST;
			alt_in_o <= GPIO_RST;
			keep_q   <= GPIO_RST;
			sense_o  <= GPIO_RST;
			irq_o    <= 2'h0;
			wake_o   <= 1'b0;
			clkdiv_q <= 1'b0;
		end else begin
			in_q     <= in_v;
			alt_in_o <= in_v;
			keep_q   <= pin_s;
			sense_o  <= hit;
			irq_o[0] <= flag_d[0] & (ictrl_q[IL0_LSB+:2] != 2'h0);
			irq_o[1] <= flag_d[1] & (ictrl_q[IL1_LSB+:2] != 2'h0);
			wake_o   <= |((mask0_q | mask1_q) & hit_a);
			clkdiv_q <= ~clkdiv_q;
		end
	end
	assign irq_lvl0_o = ictrl_q[IL0_LSB+:2];
	assign irq_lvl1_o = ictrl_q[IL1_LSB+:2];

	////////////////////////////////////////////////////////////////////////////////
	// Output path and driver modes
	for (genvar i = 0; i < GPIO_PINS; i++) begin : g_drv
		wire logic ev_pin  = (i == EVOUT_PIN) & pctrl_q[PC_EVOUT];
		wire logic clk_pin = (i == CLKOUT_PIN) & pctrl_q[PC_CLKOUT];
		wire logic src     = alt_en_i[i] ? alt_out_i[i]
			: ev_pin ? ev7_i : clk_pin ? clkdiv_q : out_q[i];
		assign drv_v[i]  = src ^ inv[i];
		assign drv_en[i] = alt_en_i[i] ? alt_dir_i[i] : (dir_q[i] | ev_pin | clk_pin);
		always_comb begin
			oe[i] = drv_en[i];
			pu[i] = 1'b0;
			pd[i] = 1'b0;
			unique case (gpio_opc_e'(cfg_q[i][OPC_MSB:OPC_LSB]))
				OPC_TOTEM: ;
				OPC_KEEP: begin
					pu[i] = ~drv_en[i] & keep_q[i];
					pd[i] = ~drv_en[i] & ~keep_q[i];
				end
				OPC_PULLDN: pd[i] = ~drv_en[i];
				OPC_PULLUP: pu[i] = ~drv_en[i];
				OPC_WOR:    oe[i] = drv_en[i] & drv_v[i];
				OPC_WAND:   oe[i] = drv_en[i] & ~drv_v[i];
				OPC_WOR_PD: begin
					oe[i] = drv_en[i] & drv_v[i];
					pd[i] = 1'b1;
				end
				OPC_WAND_PU: begin
					oe[i] = drv_en[i] & ~drv_v[i];
					pu[i] = 1'b1;
				end
			endcase
		end
	end

	// Pads are registered so the pin sees no decode glitches
	always_ff @(posedge ref_clk_i) begin
		if (!rst_n_i) begin
			pad_out_o  <= GPIO_RST;
			pad_oe_n_o <= ~GPIO_RST;
			pad_pu_o   <= GPIO_RST;
			pad_pd_o   <= GPIO_RST;
		end else begin
			pad_out_o  <= drv_v;
			pad_oe_n_o <= ~oe;
			pad_pu_o   <= pu;
			pad_pd_o   <= pd;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_DIRSET: assert property (w_dset |=> dir_q == ($past(dir_q) | $past(wd)))
		else $error("direction set lost or disturbed bits");
	AST_OUTCLR: assert property (w_oclr |=> out_q == ($past(out_q) & ~$past(wd)))
		else $error("output clear acted on wrong bits");
	AST_MULTI: assert property (w_cfg && multi_q != GPIO_RST
		|=> cfg_q[0] == ($past(multi_q[0]) ? $past(wd) : $past(cfg_q[0])) && multi_q == GPIO_RST)
		else $error("multi-pin configuration write misapplied");
	AST_INVIN: assert property (in_q == $past(pin_s ^ inv))
		else $error("input register does not follow inverted pin");
	AST_INVOUT: assert property (!alt_en_i[0] ##1 !alt_en_i[0]
		|-> pad_out_o[0] == $past(out_q[0] ^ inv[0]))
		else $error("pad value does not follow inverted output");
	AST_KEEP: assert property (
		gpio_opc_e'(cfg_q[1][OPC_MSB:OPC_LSB]) == OPC_KEEP && !drv_en[1]
		|=> pad_pu_o[1] == $past(keep_q[1]) && pad_pd_o[1] == !$past(keep_q[1]))
		else $error("keeper does not hold the last level");
	AST_FLAG: assert property (|(mask0_q & hit) |=> flag_q[0] ##0 irq_o[0] == (irq_lvl0_o != 2'h0))
		else $error("masked sense hit did not raise interrupt 0");
	AST_WAKE: assert property (|((mask0_q | mask1_q) & hit_a) |=> wake_o)
		else $error("wake-up missing for a masked sense hit");
	AST_ACK: assert property (req |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus acknowledge not a single cycle");
	AST_DIRCLR: assert property (w_dclr |=> dir_q == ($past(dir_q) & ~$past(wd)))
		else $error("direction clear acted on wrong bits");
	AST_OUTTGL: assert property (w_otgl |=> out_q == ($past(out_q) ^ $past(wd)))
		else $error("output toggle acted on wrong bits");
	AST_MASK1: assert property (|(mask1_q & hit) |=> flag_q[1])
		else $error("masked sense hit did not raise interrupt 1");
	AST_WIREDOR: assert property (cfg_q[3][OPC_MSB:OPC_LSB] == OPC_WOR && !drv_v[3] |=> pad_oe_n_o[3])
		else $error("wired-OR pin drove a zero");
endmodule

// ---- tb/gpio_pins.sv ----
// Model of the board side of the eight port pins.
// Assumes pad_out_i and pad_oe_n_i come from the port, with a low enable meaning the port drives.
`timescale 1ns/1ps
module gpio_pins (
	input  wire logic       ref_clk_i,  // Clock
	input  wire logic [7:0] pad_out_i,  // Port drive value
	input  wire logic [7:0] pad_oe_n_i, // Port drives, low active
	input  wire logic [7:0] pad_pu_i,   // Weak pull-up
	input  wire logic [7:0] pad_pd_i,   // Weak pull-down
	input  wire logic [7:0] ext_en_i,   // Board drives pin
	input  wire logic [7:0] ext_val_i,  // Board value
	output logic      [7:0] lvl_o       // Resolved pin level
);
	logic [7:0] flt_q = 8'h55;

	// An undriven pin with no pull wanders; a steady value would hide a missing pull
	always_ff @(posedge ref_clk_i) begin
		flt_q <= ~flt_q;
	end

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pad_oe_n_i[i])
				lvl_o[i] = pad_out_i[i];
			else if (ext_en_i[i])
				lvl_o[i] = ext_val_i[i];
			else if (pad_pu_i[i] || pad_pd_i[i])
				lvl_o[i] = pad_pu_i[i];
			else
				lvl_o[i] = flt_q[i];
		end
	end
endmodule

// ---- tb/tb_gpio_port.sv ----
// Self-checking bench for the eight-pin port: Wishbone master, pin model, alternate function stimulus.
// Assumes a one-cycle registered ack and the register map of the package.
`timescale 1ns/1ps
module tb_gpio_port;
	import gpio_pkg::*;
	logic        ref_clk_i = 0, rst_n_i = 0, cyc = 0, stb = 0, we = 0, ev7 = 0;
	// Board holds every pin low from the start so the input register reads a known value
	logic [7:0]  adr = 0, ext_en = 8'hff, ext_val = 0, alt_en = 0, alt_out = 0, alt_dir = 0;
	logic [7:0]  b, m, t, e, lvl, pad_out, oe_n, pu, pd, alt_in, sense;
	logic [3:0]  sel = 0;
	logic [31:0] dat = 0, wb_dat_o;
	logic [1:0]  irq, lvl0, lvl1;
	logic        wb_ack_o, wake, fal, a;
	int          num_errors = 0, total_checks = 0, cyc_cnt = 0, hits = 0, wakes = 0;
	logic [31:0] exp_q[$];
	string       nam_q[$];
	logic [7:0]  opc_t[5] = '{8'h00, 8'h08, 8'h0c, 8'h18, 8'h1c};
	logic [1:0]  pull_t[5] = '{2'b00, 2'b01, 2'b10, 2'b01, 2'b10};

	always #5 ref_clk_i = ~ref_clk_i;

	gpio_port u_gpio_port (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .pad_in_i(lvl), .pad_out_o(pad_out), .pad_oe_n_o(oe_n), .pad_pu_o(pu),
		.pad_pd_o(pd), .alt_en_i(alt_en), .alt_out_i(alt_out), .alt_dir_i(alt_dir), .alt_in_o(alt_in),
		.ev7_i(ev7), .sense_o(sense), .irq_o(irq), .irq_lvl0_o(lvl0), .irq_lvl1_o(lvl1), .wake_o(wake));

	gpio_pins u_gpio_pins (.ref_clk_i(ref_clk_i), .pad_out_i(pad_out), .pad_oe_n_i(oe_n), .pad_pu_i(pu),
		.pad_pd_i(pd), .ext_en_i(ext_en), .ext_val_i(ext_val), .lvl_o(lvl));

	////////////////////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] x, input logic [31:0] s);
		total_checks++;
		if (s !== x) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", n, x, s);
		end
	endtask

	task test_done;
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Read data is judged here, at the ack edge, against the oldest note
	always @(posedge ref_clk_i) begin
		cyc_cnt++;
		if (sense[1] === 1'b1) hits++;
		if (wake === 1'b1) wakes++;
		if (wb_ack_o === 1'b1 && we === 1'b0 && exp_q.size() > 0)
			chk(nam_q.pop_front(), exp_q.pop_front(), wb_dat_o);
		if (cyc_cnt > 20000) begin
			num_errors++;
			test_done();
		end
	end

	task wb(input logic [7:0] ad, input logic w, input logic [7:0] d);
		@(posedge ref_clk_i);
		cyc <= 1;
		stb <= 1;
		we  <= w;
		adr <= ad;
		sel <= 4'hf;
		dat <= {24'h0, d};
		do @(posedge ref_clk_i); while (wb_ack_o !== 1'b1);
		cyc <= 0;
		stb <= 0;
		we  <= 0;
	endtask

	task rd(input logic [7:0] ad, input logic [7:0] x, input string n);
		exp_q.push_back({24'h0, x});
		nam_q.push_back(n);
		wb(ad, 0, 8'h00);
	endtask

	task wt(input int c);
		repeat (c) @(posedge ref_clk_i);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(32'h0d2e));
		wt(3);
		rst_n_i <= 1;
		chk("oe_n reset", 32'hff, 32'(oe_n));
		foreach (opc_t[i]) rd(8'h00 + 8'(i) * 8'h10, 8'h00, "reset value");
		rd(8'hfc, 8'h00, "unmapped");
		$display("test reset done");

		for (int k = 0; k < 2; k++) begin
			b = $urandom;
			m = $urandom;
			t = $urandom;
			adr <= 8'h00;
			wb(8'(k) * 8'h10, 1, b);
			wb(8'(k) * 8'h10 + 8'h04, 1, m);
			rd(8'(k) * 8'h10, b | m, "set");
			wb(8'(k) * 8'h10 + 8'h08, 1, m);
			rd(8'(k) * 8'h10, b & ~m, "clear");
			e = (b & ~m) ^ t;
			wb(8'(k) * 8'h10 + 8'h0c, 1, t);
			rd(8'(k) * 8'h10, e, "toggle");
			wt(2);
			chk("pad drive", 32'(k ? e : 8'(~e)), 32'(k ? pad_out : oe_n));
		end
		$display("test set clear toggle done");

		wb(OFS_DIR, 1, 8'h00);
		b = $urandom;
		ext_en <= 8'hff;
		ext_val <= b;
		wt(5);
		rd(OFS_IN, b, "input");
		wb(OFS_MULTI, 1, 8'hf0);
		wb(OFS_PINCFG0 + 8'h10, 1, 8'h40);
		rd(OFS_PINCFG0 + 8'h1c, 8'h40, "multi cfg");
		rd(OFS_PINCFG0, 8'h00, "unmasked cfg");
		wt(5);
		rd(OFS_IN, b ^ 8'hf0, "inverted input");
		wb(OFS_OUT, 1, 8'h0f);
		wt(2);
		chk("inverted out", 32'hff, 32'(pad_out));
		wb(OFS_MULTI, 1, 8'hf0);
		wb(OFS_PINCFG0 + 8'h10, 1, 8'h00);
		$display("test inversion done");

		wb(OFS_MASK0, 1, 8'h02);
		wb(OFS_INTCTRL, 1, 8'h09);
		chk("irq levels", 32'h09, 32'({lvl1, lvl0}));
		for (int c = 0; c < 2; c++) begin
			wb(OFS_PCTRL, 1, 8'(c));
			for (int md = 0; md < 4; md++) begin
				ext_val <= 8'h02;
				wt(5);
				wb(OFS_PINCFG0 + 8'h04, 1, 8'(md));
				wb(OFS_FLAGS, 1, 8'h03);
				hits = 0;
				wakes = 0;
				ext_val <= 8'h00;
				wt(8);
				fal = (md != 1);
				chk("fall hit", 32'(fal), md == 3 ? 32'(hits > 0) : 32'(hits));
				chk("wake", 32'(fal), 32'(wakes > 0));
				chk("irq", 32'(fal), 32'(irq));
				rd(OFS_FLAGS, 8'(fal), "flags");
				hits = 0;
				ext_val <= 8'h02;
				wt(8);
				if (md < 3) chk("rise hit", 32'(md < 2), 32'(hits));
			end
		end
		wb(OFS_PINCFG0 + 8'h04, 1, 8'h42);
		wt(5);
		hits = 0;
		ext_val <= 8'h00;
		wt(8);
		chk("inv fall", 32'h0, 32'(hits));
		ext_val <= 8'h02;
		wt(8);
		chk("inv rise", 32'h1, 32'(hits));
		// Second interrupt alone: pin 1 moves from mask 0 to mask 1
		wb(OFS_MASK0, 1, 8'h00);
		wb(OFS_MASK1, 1, 8'h02);
		ext_val <= 8'h00;
		wt(8);
		wb(OFS_FLAGS, 1, 8'h03);
		ext_val <= 8'h02;
		wt(8);
		chk("irq1", 32'h2, 32'(irq));
		rd(OFS_FLAGS, 8'h02, "flags1");
		$display("test sensing done");

		wb(OFS_PINCFG0 + 8'h08, 1, 8'h40);
		alt_en <= 8'h04;
		alt_dir <= 8'h04;
		alt_out <= 8'h04;
		wt(6);
		chk("alt drive", 32'h0, 32'({pad_out[2], oe_n[2]}));
		chk("alt in", 32'h1, 32'(alt_in[2]));
		alt_en <= 8'h00;
		$display("test alternate done");

		ext_en <= 8'hf7;
		foreach (opc_t[i]) begin
			wb(OFS_PINCFG0 + 8'h0c, 1, opc_t[i]);
			wt(3);
			chk("pulls", 32'(pull_t[i]), 32'({pu[3], pd[3]}));
		end
		for (int v = 0; v < 2; v++) begin
			ext_en <= 8'hff;
			ext_val <= 8'(v) << 3;
			wb(OFS_PINCFG0 + 8'h0c, 1, 8'h04);
			wt(6);
			ext_en <= 8'hf7;
			wt(6);
			chk("keeper", v ? 32'h2 : 32'h1, 32'({pu[3], pd[3]}));
		end
		wb(OFS_DIRSET, 1, 8'h08);
		for (int k = 0; k < 2; k++) begin
			wb(OFS_PINCFG0 + 8'h0c, 1, 8'(4 + k) << 2);
			wb(OFS_OUTCLR, 1, 8'h08);
			wt(2);
			chk("wired zero", 32'(k == 0), 32'(oe_n[3]));
			wb(OFS_OUTSET, 1, 8'h08);
			wt(2);
			chk("wired one", 32'(k == 1), 32'(oe_n[3]));
		end
		$display("test drivers done");

		wb(OFS_PCTRL, 1, 8'h02);
		ev7 <= 1;
		wt(3);
		chk("event pin", 32'h2, 32'({pad_out[6], oe_n[6]}));
		ev7 <= 0;
		wt(3);
		chk("event low", 32'h0, 32'(pad_out[6]));
		wb(OFS_PCTRL, 1, 8'h04);
		wt(3);
		a = pad_out[7];
		wt(1);
		chk("clock pin", 32'(!a), 32'(pad_out[7]));
		$display("test event clock done");

		wb(OFS_DIR, 1, 8'h5a);
		wb(OFS_VPCTRL, 1, 8'h01);
		rd(OFS_VP_DIR, 8'h5a, "virtual dir");
		wb(OFS_VPCTRL, 1, 8'h00);
		rd(OFS_VP_DIR, 8'h00, "virtual off");
		$display("test virtual done");
		test_done();
	end
endmodule
